// ==== hw/segment_pointer_registers.sv ====
// Segment pointer register file with top-of-stack cache and Wishbone slave
`timescale 1ns/1ps
`default_nettype none

// Operation
// - Code and data references are formed from their base registers; stack references from logical top.
// - One active code segment and one active data segment are described.
// - Code base holds a 16-bit address of the code segment's first word.
// - A 4-bit code bank selects the memory bank of the code segment.
// - Code limit holds a 16-bit address of the code segment's last word.
// - Instruction counter is the 16-bit address of the executing instruction.
// - Instruction counter never goes below code base or above code limit; rewriting either bound is not checked against it.
// - Data limit holds a 16-bit address of the lowest user data word.
// - Data base holds a 16-bit address of the global stack area start.
// - A 4-bit data bank selects the bank of stack or extra data segment.
// - Frame marker holds a 16-bit address of the current stack marker's fourth word.
// - Frame marker stays within data base and stack limit, below base when privileged; rewriting either bound is not checked against it.
// - Stack memory top holds the 16-bit address of the last word in memory.
// - Stack memory top always stays between data base and stack limit; rewriting either bound is not checked against it.
// - Cached element count is 3 bits and only ever holds 0 to 4.
// - Logical top is not stored; it is stack memory top plus cached count.
// - Cache entries 0 to 3 hold words at logical top minus 0 to 3.
// - Stack limit holds a 16-bit address of the stack's last usable word.
// - A 4-bit stack bank qualifies top, data limit, frame and stack limit addresses.
// - Stack bank may differ from data bank for split-stack use.
// - Push stores the word and advances logical top by one; pop steps back one.
module segment_pointer_registers (
  input  wire  logic                    mclk,
  input  wire  logic                    rst_b,
  input  wire  logic                    wb_cyc_i,
  input  wire  logic                    wb_stb_i,
  input  wire  logic                    wb_we_i,
  input  wire  logic [7:0]              wb_adr_i,
  input  wire  logic [3:0]              wb_sel_i,
  input  wire  logic [31:0]             wb_dat_i,
  output logic       [31:0]             wb_dat_o,
  output logic                          wb_ack_o,
  input  wire  logic                    priv_mode,
  input  wire  segptr_pkg::ucode_cmd_t  cmd,
  output logic       [15:0]             instr_addr_o,
  output logic       [15:0]             logical_top_o,
  output segptr_pkg::mem_ref_t          mem_ref_o,
  output segptr_pkg::spill_t            spill_o,
  output segptr_pkg::viol_t             viol_o
);

  logic [15:0] code_base_q;
  logic [3:0]  code_bank_q;
  logic [15:0] code_limit_q;
  logic [15:0] instruction_counter_q;
  logic [15:0] data_limit_q;
  logic [15:0] data_base_q;
  logic [3:0]  data_bank_q;
  logic [15:0] frame_marker_q;
  logic [15:0] stack_memory_top_q;
  logic [2:0]  cached_element_count_q;
  logic [15:0] stack_limit_q;
  logic [3:0]  stack_bank_q;
  logic [15:0] top_cache_q [segptr_pkg::CACHE_DEPTH];
  logic        ack_q;
  logic [31:0] rd_data_q;
  logic [31:0] rd_data_d;

  logic [15:0] logical_top;
  logic        wr;
  logic        push_ok;
  logic        push_bad;
  logic        pop_ok;
  logic        pop_bad;
  logic        spill;
  logic        ic_req;
  logic [15:0] ic_cand;
  logic        ic_ok;
  logic [15:0] wr_word;
  logic        wr_ic;
  logic        wr_ic_ok;
  logic        wr_fm;
  logic        wr_fm_ok;
  logic        wr_smt;
  logic        wr_smt_ok;
  logic        wr_cnt;
  logic        wr_cnt_ok;
  logic        wr_bad;

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [1:0] sel, input logic [15:0] dat);
    merge16 = {sel[1] ? dat[15:8] : old[15:8], sel[0] ? dat[7:0] : old[7:0]};
  endfunction

  // Kept as a sum so the two halves can move independently in one cycle
  assign logical_top = 16'(stack_memory_top_q + 16'(cached_element_count_q));

  // Bus write lands on the edge at which the master sees ack
  assign wr      = wb_cyc_i && wb_stb_i && wb_we_i && ack_q;
  assign wr_word = wb_dat_i[15:0];

  // Stack motion; push wins when both are asked at once
  assign push_ok  = cmd.push && (logical_top < stack_limit_q);
  assign push_bad = cmd.push && !push_ok;
  assign pop_ok   = cmd.pop && !cmd.push && (logical_top > data_base_q);
  assign pop_bad  = cmd.pop && !cmd.push && !pop_ok;
  assign spill    = push_ok && (cached_element_count_q == segptr_pkg::CACHE_MAX);

  assign ic_req  = cmd.ic_load || cmd.ic_step;
  assign ic_cand = cmd.ic_load ? cmd.ic_target : 16'(instruction_counter_q + segptr_pkg::ONE_WORD);
  assign ic_ok   = (ic_cand >= code_base_q) && (ic_cand <= code_limit_q);

  assign wr_ic     = wr && (wb_adr_i == segptr_pkg::OFS_INSTR_CNT);
  assign wr_ic_ok  = (merge16(instruction_counter_q, wb_sel_i[1:0], wr_word) >= code_base_q)
                  && (merge16(instruction_counter_q, wb_sel_i[1:0], wr_word) <= code_limit_q);
  assign wr_fm     = wr && (wb_adr_i == segptr_pkg::OFS_FRAME);
  assign wr_fm_ok  = (merge16(frame_marker_q, wb_sel_i[1:0], wr_word) <= stack_limit_q)
                  && (priv_mode || merge16(frame_marker_q, wb_sel_i[1:0], wr_word) >= data_base_q);
  assign wr_smt    = wr && (wb_adr_i == segptr_pkg::OFS_STACK_TOP);
  assign wr_smt_ok = (merge16(stack_memory_top_q, wb_sel_i[1:0], wr_word) >= data_base_q)
                  && (merge16(stack_memory_top_q, wb_sel_i[1:0], wr_word) <= stack_limit_q);
  assign wr_cnt    = wr && (wb_adr_i == segptr_pkg::OFS_CACHED_CNT) && wb_sel_i[0];
  assign wr_cnt_ok = wb_dat_i[2:0] <= segptr_pkg::CACHE_MAX;
  assign wr_bad    = (wr_ic && !wr_ic_ok) || (wr_fm && !wr_fm_ok)
                  || (wr_smt && !wr_smt_ok) || (wr_cnt && !wr_cnt_ok);

  // Wishbone handshake: one wait cycle, ack drops after one cycle
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ack_q     <= 1'b0;
      rd_data_q <= 32'h0000_0000;
    end
    else
    begin
      ack_q     <= wb_cyc_i && wb_stb_i && !ack_q;
      rd_data_q <= rd_data_d;
    end
  end

  // Unmapped offsets read as zero and are still acknowledged
  always_comb
  begin
    rd_data_d = 32'h0000_0000;
    case (wb_adr_i)
      segptr_pkg::OFS_CODE_BASE:   rd_data_d[15:0] = code_base_q;
      segptr_pkg::OFS_CODE_BANK:   rd_data_d[3:0]  = code_bank_q;
      segptr_pkg::OFS_CODE_LIMIT:  rd_data_d[15:0] = code_limit_q;
      segptr_pkg::OFS_INSTR_CNT:   rd_data_d[15:0] = instruction_counter_q;
      segptr_pkg::OFS_DATA_LIMIT:  rd_data_d[15:0] = data_limit_q;
      segptr_pkg::OFS_DATA_BASE:   rd_data_d[15:0] = data_base_q;
      segptr_pkg::OFS_DATA_BANK:   rd_data_d[3:0]  = data_bank_q;
      segptr_pkg::OFS_FRAME:       rd_data_d[15:0] = frame_marker_q;
      segptr_pkg::OFS_STACK_TOP:   rd_data_d[15:0] = stack_memory_top_q;
      segptr_pkg::OFS_CACHED_CNT:  rd_data_d[2:0]  = cached_element_count_q;
      segptr_pkg::OFS_STACK_LIMIT: rd_data_d[15:0] = stack_limit_q;
      segptr_pkg::OFS_STACK_BANK:  rd_data_d[3:0]  = stack_bank_q;
      segptr_pkg::OFS_LOGICAL_TOP: rd_data_d[15:0] = logical_top;
      default:
      begin
        if (wb_adr_i >= segptr_pkg::OFS_CACHE_0 && wb_adr_i <= segptr_pkg::OFS_CACHE_3 && wb_adr_i[1:0] == 2'h0)
          rd_data_d[15:0] = top_cache_q[2'(wb_adr_i[3:2] - segptr_pkg::OFS_CACHE_0[3:2])];
      end
    endcase
  end

  // Plain segment bounds and banks; banks are independent so split stacks work
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      code_base_q   <= segptr_pkg::RST_ADDR;
      code_bank_q   <= segptr_pkg::RST_BANK;
      code_limit_q  <= segptr_pkg::RST_ADDR;
      data_limit_q  <= segptr_pkg::RST_ADDR;
      data_base_q   <= segptr_pkg::RST_ADDR;
      data_bank_q   <= segptr_pkg::RST_BANK;
      stack_limit_q <= segptr_pkg::RST_ADDR;
      stack_bank_q  <= segptr_pkg::RST_BANK;
    end
    else if (wr)
    begin
      case (wb_adr_i)
        segptr_pkg::OFS_CODE_BASE:   code_base_q   <= merge16(code_base_q, wb_sel_i[1:0], wr_word);
        segptr_pkg::OFS_CODE_BANK:   code_bank_q   <= wb_sel_i[0] ? wb_dat_i[3:0] : code_bank_q;
        segptr_pkg::OFS_CODE_LIMIT:  code_limit_q  <= merge16(code_limit_q, wb_sel_i[1:0], wr_word);
        segptr_pkg::OFS_DATA_LIMIT:  data_limit_q  <= merge16(data_limit_q, wb_sel_i[1:0], wr_word);
        segptr_pkg::OFS_DATA_BASE:   data_base_q   <= merge16(data_base_q, wb_sel_i[1:0], wr_word);
        segptr_pkg::OFS_DATA_BANK:   data_bank_q   <= wb_sel_i[0] ? wb_dat_i[3:0] : data_bank_q;
        segptr_pkg::OFS_STACK_LIMIT: stack_limit_q <= merge16(stack_limit_q, wb_sel_i[1:0], wr_word);
        segptr_pkg::OFS_STACK_BANK:  stack_bank_q  <= wb_sel_i[0] ? wb_dat_i[3:0] : stack_bank_q;
        default:
        begin
        end
      endcase
    end
  end

  // Program counter; a bad step or load leaves it where it is
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      instruction_counter_q <= segptr_pkg::RST_ADDR;
    else if (wr_ic)
    begin
      if (wr_ic_ok)
        instruction_counter_q <= merge16(instruction_counter_q, wb_sel_i[1:0], wr_word);
    end
    else if (ic_req && ic_ok)
      instruction_counter_q <= ic_cand;
  end

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      frame_marker_q <= segptr_pkg::RST_ADDR;
    else if (wr_fm && wr_fm_ok)
      frame_marker_q <= merge16(frame_marker_q, wb_sel_i[1:0], wr_word);
  end

  // Stack memory top: bus wins over stack motion in the same cycle
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      stack_memory_top_q <= segptr_pkg::RST_ADDR;
    else if (wr_smt)
    begin
      if (wr_smt_ok)
        stack_memory_top_q <= merge16(stack_memory_top_q, wb_sel_i[1:0], wr_word);
    end
    else if (spill)
      stack_memory_top_q <= 16'(stack_memory_top_q + segptr_pkg::ONE_WORD);
    else if (pop_ok && cached_element_count_q == segptr_pkg::RST_CNT)
      stack_memory_top_q <= 16'(stack_memory_top_q - segptr_pkg::ONE_WORD);
  end

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      cached_element_count_q <= segptr_pkg::RST_CNT;
    else if (wr_cnt)
    begin
      if (wr_cnt_ok)
        cached_element_count_q <= wb_dat_i[2:0];
    end
    else if (push_ok && !spill)
      cached_element_count_q <= 3'(cached_element_count_q + 3'h1);
    else if (pop_ok && cached_element_count_q != segptr_pkg::RST_CNT)
      cached_element_count_q <= 3'(cached_element_count_q - 3'h1);
  end

  // Cache entries shift with the logical top; a popped-through entry keeps stale data
  for (genvar i = 0; i < segptr_pkg::CACHE_DEPTH; i++)
  begin : g_cache
    always_ff @(posedge mclk or negedge rst_b)
    begin
      if (!rst_b)
        top_cache_q[i] <= segptr_pkg::RST_ADDR;
      else if (push_ok)
        top_cache_q[i] <= (i == 0) ? cmd.push_data : top_cache_q[(i == 0) ? 0 : i - 1];
      else if (pop_ok)
        top_cache_q[i] <= top_cache_q[(i == segptr_pkg::CACHE_DEPTH - 1) ? i : i + 1];
    end
  end

  // Outputs toward the datapath, all registered
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      mem_ref_o     <= '0;
      spill_o       <= '0;
      viol_o        <= '0;
      logical_top_o <= segptr_pkg::RST_ADDR;
    end
    else
    begin
      mem_ref_o.valid <= cmd.ref_req;
      case (cmd.ref_space)
        segptr_pkg::SPACE_CODE:
        begin
          mem_ref_o.bank <= code_bank_q;
          mem_ref_o.addr <= 16'(code_base_q + cmd.ref_offset);
        end
        segptr_pkg::SPACE_STACK:
        begin
          mem_ref_o.bank <= stack_bank_q;
          mem_ref_o.addr <= 16'(logical_top - cmd.ref_offset);
        end
        default:
        begin
          mem_ref_o.bank <= data_bank_q;
          mem_ref_o.addr <= 16'(data_base_q + cmd.ref_offset);
        end
      endcase
      spill_o.valid <= spill;
      spill_o.bank  <= stack_bank_q;
      spill_o.addr  <= 16'(stack_memory_top_q + segptr_pkg::ONE_WORD);
      spill_o.data  <= top_cache_q[segptr_pkg::CACHE_DEPTH - 1];
      viol_o        <= '{push: push_bad, pop: pop_bad, instr: ic_req && !ic_ok && !wr_ic, bus_write: wr_bad};
      logical_top_o <= logical_top;
    end
  end

  assign wb_ack_o     = ack_q;
  assign wb_dat_o     = rd_data_q;
  assign instr_addr_o = instruction_counter_q;

  // Checks
  cnt_range_a: assert property (@(posedge mclk) disable iff (!rst_b)
    cached_element_count_q <= segptr_pkg::CACHE_MAX) else $error("cached count above four");
  ic_bounds_a: assert property (@(posedge mclk) disable iff (!rst_b)
    $changed(instruction_counter_q) |-> instruction_counter_q >= $past(code_base_q)
      && instruction_counter_q <= $past(code_limit_q)) else $error("instruction counter left code segment");
  smt_bounds_a: assert property (@(posedge mclk) disable iff (!rst_b)
    $changed(stack_memory_top_q) |-> stack_memory_top_q >= $past(data_base_q)
      && stack_memory_top_q <= $past(stack_limit_q)) else $error("stack memory top out of bounds");
  frame_bounds_a: assert property (@(posedge mclk) disable iff (!rst_b)
    $changed(frame_marker_q) |-> frame_marker_q <= $past(stack_limit_q)
      && ($past(priv_mode) || frame_marker_q >= $past(data_base_q))) else $error("frame marker out of bounds");
  top_sum_a: assert property (@(posedge mclk) disable iff (!rst_b)
    ##1 logical_top_o == 16'($past(stack_memory_top_q) + 16'($past(cached_element_count_q))))
    else $error("logical top not the sum");
  push_step_a: assert property (@(posedge mclk) disable iff (!rst_b)
    push_ok && !wr |=> logical_top == 16'($past(logical_top) + 16'h0001) && top_cache_q[0] == $past(cmd.push_data))
    else $error("push did not advance top");
  pop_step_a: assert property (@(posedge mclk) disable iff (!rst_b)
    pop_ok && !wr |=> logical_top == 16'($past(logical_top) - 16'h0001)) else $error("pop did not step back");
  blocked_push_a: assert property (@(posedge mclk) disable iff (!rst_b)
    push_bad && !wr |=> $stable(logical_top) && viol_o.push ##1 (viol_o.push == $past(push_bad)))
    else $error("blocked push moved the stack");
  ack_pulse_a: assert property (@(posedge mclk) disable iff (!rst_b)
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o) else $error("ack not a one-cycle answer");
  code_ref_a: assert property (@(posedge mclk) disable iff (!rst_b)
    cmd.ref_req && cmd.ref_space == segptr_pkg::SPACE_CODE |=> mem_ref_o.valid
      && mem_ref_o.addr == 16'($past(code_base_q) + $past(cmd.ref_offset))) else $error("code reference not base relative");

  spill_addr_a: assert property (@(posedge mclk) disable iff (!rst_b)
    spill |=> spill_o.valid && spill_o.addr == 16'($past(stack_memory_top_q) + 16'h0001)
      && spill_o.bank == $past(stack_bank_q)) else $error("spill not at next memory word");

  spill_c: cover property (@(posedge mclk) disable iff (!rst_b) spill ##1 spill_o.valid);
  blocked_pop_c: cover property (@(posedge mclk) disable iff (!rst_b) pop_bad ##1 viol_o.pop);
  pop_c: cover property (@(posedge mclk) disable iff (!rst_b) pop_ok && cached_element_count_q == 3'h0);
  viol_c: cover property (@(posedge mclk) disable iff (!rst_b) wr_bad ##1 viol_o.bus_write);

endmodule // segment_pointer_registers

`default_nettype wire

// ==== shared/segptr_pkg.sv ====
// Constants, field layouts and carrier types for the segment pointer register file
package segptr_pkg;

  localparam int unsigned ADDR_W      = 16;
  localparam int unsigned BANK_W      = 4;
  localparam int unsigned CNT_W       = 3;
  localparam int unsigned CACHE_DEPTH = 4;
  localparam logic [2:0]  CACHE_MAX   = 3'h4;

  // Register byte offsets on the Wishbone bus, one aligned word each
  localparam logic [7:0] OFS_CODE_BASE   = 8'h00;
  localparam logic [7:0] OFS_CODE_BANK   = 8'h04;
  localparam logic [7:0] OFS_CODE_LIMIT  = 8'h08;
  localparam logic [7:0] OFS_INSTR_CNT   = 8'h0C;
  localparam logic [7:0] OFS_DATA_LIMIT  = 8'h10;
  localparam logic [7:0] OFS_DATA_BASE   = 8'h14;
  localparam logic [7:0] OFS_DATA_BANK   = 8'h18;
  localparam logic [7:0] OFS_FRAME       = 8'h1C;
  localparam logic [7:0] OFS_STACK_TOP   = 8'h20;
  localparam logic [7:0] OFS_CACHED_CNT  = 8'h24;
  localparam logic [7:0] OFS_STACK_LIMIT = 8'h28;
  localparam logic [7:0] OFS_STACK_BANK  = 8'h2C;
  localparam logic [7:0] OFS_LOGICAL_TOP = 8'h30;
  localparam logic [7:0] OFS_CACHE_0     = 8'h34;
  localparam logic [7:0] OFS_CACHE_3     = 8'h40;

  // Values after reset, and the one-word address step
  localparam logic [15:0] RST_ADDR = 16'h0000;
  localparam logic [3:0]  RST_BANK = 4'h0;
  localparam logic [2:0]  RST_CNT  = 3'h0;
  localparam logic [15:0] ONE_WORD = 16'h0001;

  typedef enum logic [1:0] {
    SPACE_CODE  = 2'b00,
    SPACE_DATA  = 2'b01,
    SPACE_STACK = 2'b11
  } ref_space_t;

  typedef struct packed {
    logic        push;
    logic        pop;
    logic [15:0] push_data;
    logic        ic_step;
    logic        ic_load;
    logic [15:0] ic_target;
    logic        ref_req;
    ref_space_t  ref_space;
    logic [15:0] ref_offset;
  } ucode_cmd_t;

  typedef struct packed {
    logic        valid;
    logic [3:0]  bank;
    logic [15:0] addr;
  } mem_ref_t;

  typedef struct packed {
    logic        valid;
    logic [3:0]  bank;
    logic [15:0] addr;
    logic [15:0] data;
  } spill_t;

  typedef struct packed {
    logic push;
    logic pop;
    logic instr;
    logic bus_write;
  } viol_t;

endpackage

// ==== testbench/segment_pointer_registers_bench.sv ====
// Self-checking bench for the segment pointer register file
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin bad_count++; \
  $display("mismatch at %0t: got %h expected %h", $time, (got), (exp)); end end

module segment_pointer_registers_bench;
  logic                    mclk = 1'b0, rst_b = 1'b0, priv_mode = 1'b0;
  logic                    wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0, wb_ack;
  logic [7:0]              wb_adr = 8'h00;
  logic [3:0]              wb_sel = 4'h0, sel_w = 4'hf;
  logic [31:0]             wb_wdat = 32'h0000_0000, wb_rdat, rd;
  logic [15:0]             instr_addr, ltop;
  segptr_pkg::ucode_cmd_t  cmd, c;
  segptr_pkg::mem_ref_t    mref, last_ref;
  segptr_pkg::spill_t      spill;
  segptr_pkg::viol_t       viol, vq[$];
  segptr_pkg::spill_t      sq[$];
  logic [15:0]             pushed[$], d;
  int                      bad_count = 0, n_tests = 0, seed = 32'hce42;

  always #2 mclk = ~mclk;

  segment_pointer_registers dut (.mclk(mclk), .rst_b(rst_b), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
    .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat),
    .wb_ack_o(wb_ack), .priv_mode(priv_mode), .cmd(cmd), .instr_addr_o(instr_addr),
    .logical_top_o(ltop), .mem_ref_o(mref), .spill_o(spill), .viol_o(viol));
  ucode_model u_model (.mclk(mclk), .rst_b(rst_b), .cmd(cmd));

  // Pulses are collected so a check never races the edge that raised them
  always @(posedge mclk)
  begin
    // Outputs are unknown until the first reset edge, so reset gates the violation capture
    if (rst_b && viol !== 4'h0) vq.push_back(viol);
    if (spill.valid === 1'b1) sq.push_back(spill);
    if (mref.valid === 1'b1) last_ref = mref;
  end

  task automatic wb_xfer(input logic we, input logic [7:0] a, input logic [31:0] dat);
    int n;
    n = 0;
    @(posedge mclk);
    {wb_cyc, wb_stb, wb_we, wb_adr, wb_wdat, wb_sel} <= {2'b11, we, a, dat, sel_w};
    do @(posedge mclk); while (wb_ack !== 1'b1 && ++n < 16);
    rd = wb_rdat;
    if (n == 16) bad_count++;
    {wb_cyc, wb_stb, wb_we} <= 3'b000;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    wb_xfer(1'b0, a, 32'h0000_0000);
    `CHK(rd, exp)
  endtask

  task automatic viol_chk(input logic [3:0] exp);
    segptr_pkg::viol_t acc;
    acc = '0;
    repeat (3) @(negedge mclk);
    foreach (vq[i]) acc |= vq[i];
    vq.delete();
    `CHK(acc, exp)
  endtask

  task automatic op(input logic push, input logic pop, input logic ld, input logic step, input logic [15:0] v);
    c = '0;
    {c.push, c.pop, c.ic_load, c.ic_step} = {push, pop, ld, step};
    c.push_data = v;
    c.ic_target = v;
    u_model.issue(c);
  endtask

  function automatic logic [15:0] exp_top(input logic [15:0] smt, input logic [2:0] cnt);
    return smt + {13'h0000, cnt};
  endfunction

  function automatic logic [20:0] exp_ref(input int s, input logic [15:0] off);
    if (s == 0) return {1'b1, 4'h5, 16'h0100 + off};
    if (s == 3) return {1'b1, 4'h9, exp_top(16'h0200, 3'h0) - off};
    return {1'b1, 4'h3, 16'h0200 + off};
  endfunction

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // Set-up order lets every checked pointer write pass its bounds when it is made
  localparam logic [7:0]  SET_OFS[11] = '{8'h08, 8'h0C, 8'h00, 8'h28, 8'h20, 8'h14, 8'h1C, 8'h04, 8'h18, 8'h2C,
                                          8'h10};
  localparam logic [15:0] SET_VAL[11] = '{16'h01FF, 16'h0100, 16'h0100, 16'h02FF, 16'h0200, 16'h0200, 16'h0250,
                                          16'h0005, 16'h0003, 16'h0009, 16'h0180};

  initial
  begin
    repeat (4) @(posedge mclk);
    rst_b <= 1'b1;
    for (int k = 0; k < 17; k++) rd_chk(8'(4 * k), 32'h0000_0000);
    $display("reset values done");
    foreach (SET_OFS[k]) wb_xfer(1'b1, SET_OFS[k], {16'hFFFF, SET_VAL[k]});
    foreach (SET_OFS[k]) rd_chk(SET_OFS[k], {16'h0000, SET_VAL[k]});
    `CHK(instr_addr, 16'h0100)
    $display("register set-up done");
    for (int s = 0; s < 4; s++)
    begin
      d = 16'($random(seed)) & 16'h00FF;
      c = '0;
      c.ref_req = 1'b1;
      c.ref_space = segptr_pkg::ref_space_t'(s[1:0]);
      c.ref_offset = d;
      u_model.issue(c);
      u_model.idle(s);
      repeat (3) @(negedge mclk);
      `CHK(last_ref, exp_ref(s, d))
    end
    $display("references done");
    for (int k = 0; k < 6; k++)
    begin
      d = 16'($random(seed));
      pushed.push_back(d);
      op(1'b1, 1'b0, 1'b0, 1'b0, d);
    end
    u_model.idle(2);
    rd_chk(8'h24, 32'h0000_0004);
    rd_chk(8'h20, 32'h0000_0202);
    rd_chk(8'h30, {16'h0000, exp_top(16'h0202, 3'h4)});
    `CHK(ltop, 16'h0206)
    for (int k = 0; k < 4; k++) rd_chk(8'(8'h34 + 4 * k), {16'h0000, pushed[5 - k]});
    for (int k = 0; k < 2; k++) `CHK(sq[k], {1'b1, 4'h9, 16'h0201 + 16'(k), pushed[k]})
    `CHK(sq.size(), 2)
    $display("push and spill done");
    repeat (6) op(1'b0, 1'b1, 1'b0, 1'b0, 16'h0000);
    u_model.idle(1);
    viol_chk(4'b0000);
    rd_chk(8'h30, 32'h0000_0200);
    op(1'b0, 1'b1, 1'b0, 1'b0, 16'h0000);
    u_model.idle(1);
    viol_chk(4'b0100);
    wb_xfer(1'b1, 8'h28, 32'h0000_0201);
    repeat (2) op(1'b1, 1'b0, 1'b0, 1'b0, 16'h1234);
    u_model.idle(1);
    viol_chk(4'b1000);
    rd_chk(8'h30, 32'h0000_0201);
    $display("stack bounds done");
    op(1'b0, 1'b0, 1'b1, 1'b0, 16'h01FF);
    op(1'b0, 1'b0, 1'b0, 1'b1, 16'h0000);
    u_model.idle(1);
    viol_chk(4'b0010);
    `CHK(instr_addr, 16'h01FF)
    op(1'b0, 1'b0, 1'b1, 1'b0, 16'h00FF);
    u_model.idle(1);
    viol_chk(4'b0010);
    wb_xfer(1'b1, 8'h0C, 32'h0000_0200);
    viol_chk(4'b0001);
    `CHK(instr_addr, 16'h01FF)
    $display("instruction bounds done");
    wb_xfer(1'b1, 8'h20, 32'h0000_01FF);
    viol_chk(4'b0001);
    wb_xfer(1'b1, 8'h24, 32'h0000_0005);
    viol_chk(4'b0001);
    wb_xfer(1'b1, 8'h1C, 32'h0000_0300);
    viol_chk(4'b0001);
    wb_xfer(1'b1, 8'h1C, 32'h0000_01F0);
    viol_chk(4'b0001);
    rd_chk(8'h1C, 32'h0000_0250);
    priv_mode <= 1'b1;
    wb_xfer(1'b1, 8'h1C, 32'h0000_01F0);
    viol_chk(4'b0000);
    rd_chk(8'h1C, 32'h0000_01F0);
    // Byte lanes: only the enabled half of a 16-bit register moves
    d = 16'($random(seed));
    sel_w = 4'h1;
    wb_xfer(1'b1, 8'h1C, {16'hFFFF, d});
    rd_chk(8'h1C, {16'h0000, 8'h01, d[7:0]});
    sel_w = 4'h2;
    wb_xfer(1'b1, 8'h08, {16'hFFFF, d});
    sel_w = 4'hf;
    rd_chk(8'h08, {16'h0000, d[15:8], 8'hFF});
    rd_chk(8'h80, 32'h0000_0000);
    $display("bus refusals done");
    rst_b <= 1'b0;
    repeat (4) @(posedge mclk);
    rst_b <= 1'b1;
    rd_chk(8'h1C, 32'h0000_0000);
    rd_chk(8'h20, 32'h0000_0000);
    `CHK(instr_addr, 16'h0000)
    `CHK(ltop, 16'h0000)
    $display("reset in mid-run done");
    finish_test();
  end

  initial
  begin
    repeat (20000) @(posedge mclk);
    bad_count++;
    finish_test();
  end
endmodule // segment_pointer_registers_bench

`default_nettype wire

// ==== testbench/ucode_model.sv ====
// Microcode sequencer stand-in that issues datapath commands
`timescale 1ns/1ps
`default_nettype none

module ucode_model (
  input  wire logic                    mclk,
  input  wire logic                    rst_b,
  output var  segptr_pkg::ucode_cmd_t  cmd
);
  initial cmd = '0;

  // Each command stands for one edge; back-to-back calls give no idle cycle between them
  task automatic issue(input segptr_pkg::ucode_cmd_t c);
    @(posedge mclk);
    cmd <= c;
  endtask

  // Idle cycles model a slow sequencer
  task automatic idle(input int n);
    @(posedge mclk);
    cmd <= '0;
    repeat (n) @(posedge mclk);
  endtask
endmodule // ucode_model

`default_nettype wire
